// file: dv/pmt_cpu_model.sv
// Core side model: one instruction cycle pulse every four clocks
`timescale 1ns/1ns
module pmt_cpu_model (
    input wire logic i_clk,    // Core clock
    input wire logic i_arst_n, // Async reset, low
    output logic o_cyc_en      // High one clock per cycle
);
    logic [1:0] phase;
    // Four phases per cycle, like the core's internal clocks
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
    assign o_cyc_en = (phase == 2'h3);
endmodule : pmt_cpu_model

// file: dv/program_memory_table_read_tb.sv
// Self-checking bench for the program store and table read block
`timescale 1ns/1ns
module program_memory_table_read_tb;
    import pmt_pkg::*;
    localparam int AW = 11;
    logic clk = 0, arst_n = 0, cyc, pcl = 0, trd = 0, hw = 0, pwe = 0, doe = 0, dout = 0;
    logic pin = 1'b1, l0, l2 = 0, stall, ext, sdo, soe, sd, sc;
    logic [AW-1:0] tgt = '0, pa = '0, pc;
    pmt_tr_e form = PMT_TR_SHORT;
    pmt_dst_s dst = '0;
    pmt_dwr_s dwr;
    logic [7:0] lo = '0, hi = '0, hwd = '0, hl;
    logic [15:0] pwd = '0, instr, w;
    int err_count = 0, checks_done = 0, seed = 32'h3C7A4835, n;
    // Nothing else drives the data line while the device does
    assign l0 = soe ? sdo : pin;
    always #10 clk = ~clk;
    pmt_cpu_model cpu (.i_clk(clk), .i_arst_n(arst_n), .o_cyc_en(cyc));
    pmt_core #(.DEPTH(2048)) dut (.i_clk(clk), .i_arst_n(arst_n), .i_cyc_en(cyc),
        .i_pc_load(pcl), .i_pc_target(tgt), .i_tbl_rd(trd), .i_tbl_form(form),
        .i_tbl_dst(dst), .i_tbl_lo_ptr(lo), .i_tbl_hi_ptr(hi), .i_hi_latch_wr(hw),
        .i_hi_latch_wdata(hwd), .i_prog_we(pwe), .i_prog_addr(pa), .i_prog_wdata(pwd),
        .i_port_a_line0(l0), .i_port_a_line2(l2), .i_prog_data_oe(doe),
        .i_prog_data_out(dout), .o_pc(pc), .o_instr(instr), .o_stall(stall), .o_dwr(dwr),
        .o_dwr_ext(ext), .o_table_high_latch(hl), .o_prog_serial_data_o(sdo),
        .o_prog_serial_data_oe(soe), .o_prog_serial_data(sd), .o_prog_serial_clock(sc));
    function automatic logic [15:0] word_of(input logic [AW-1:0] a);
        return {a[10:3], a[7:0] ^ 8'hA5};
    endfunction : word_of
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_cyc;
        n = 0;
        @(negedge clk);
        while (cyc !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 8) begin
                check("cycle enable", 16'h0000, 16'h0001);
                test_done();
            end
        end
    endtask : wait_cyc
    task automatic tbl(input pmt_tr_e f, input logic [7:0] lv, input logic [7:0] hv);
        logic [AW-1:0] a;
        lo = lv;
        hi = hv;
        form = f;
        dst = 10'($random(seed));
        a = f[0] ? {3'h7, lv} : {hv[2:0], lv};
        wait_cyc();
        // Single caller, so no table read ever overlaps another
        trd = 1'b1;
        @(negedge clk);
        trd = 1'b0;
        // Pointers move at once; the result must still come from the issued address
        lo = ~lv;
        hi = ~hv;
        check("stall", stall, 16'h0001);
        repeat (3) @(negedge clk);
        check("early write", dwr.en, 16'h0000);
        @(negedge clk);
        w = word_of(a);
        check("write", dwr.en, 16'h0001);
        check("low byte", dwr.data, w[7:0]);
        check("high latch", hl, w[15:8]);
        check("dest", dwr.dst, dst);
        check("ext flag", ext, f[1]);
        check("stall end", stall, 16'h0000);
    endtask : tbl
    initial begin
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        pwe = 1'b1;
        for (int i = 0; i < 2048; i++) begin
            pa = AW'(i);
            pwd = word_of(pa);
            @(negedge clk);
        end
        pwe = 1'b0;
        arst_n = 1'b0;
        @(negedge clk);
        arst_n = 1'b1;
        check("reset pc", pc, 16'h0000);
        wait_cyc();
        @(negedge clk);
        check("first fetch", instr, word_of(11'h000));
        check("pc step", pc, 16'h0001);
        tbl(PMT_TR_LAST, 8'hFF, 8'h00);
        tbl(PMT_TR_SHORT, 8'hFF, 8'hFF);
        for (int k = 0; k < 16; k++) begin
            tbl(pmt_tr_e'(k[1:0]), 8'($random(seed)), 8'($random(seed)));
            tgt = AW'($random(seed));
            wait_cyc();
            pcl = 1'b1;
            @(negedge clk);
            pcl = 1'b0;
            check("branch stall", stall, 16'h0001);
            repeat (4) @(negedge clk);
            check("refetch", stall, 16'h0000);
            check("branch pc", pc, tgt);
            check("fetch word", instr, word_of(tgt));
            hwd = 8'($random(seed));
            hw = 1'b1;
            @(negedge clk);
            hw = 1'b0;
            check("sw latch", hl, hwd);
            {doe, dout, pin, l2} = 4'($random(seed));
            repeat (6) @(negedge clk);
            check("data oe", soe, doe);
            if (doe) check("data out", sdo, dout);
            check("data in", sd, doe ? dout : pin);
            check("clock in", sc, l2);
        end
        test_done();
    end
endmodule : program_memory_table_read_tb

// file: src/pmt_consts.svh
// Constants for the program memory and table read block
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH
`define PMT_RESET_VECTOR 16'h0000
`define PMT_WORD_W 16
`define PMT_DEPTH_WORDS 2048
`define PMT_TBL_HI_RST 8'h00
`define PMT_SEC0 2'h0
`define PMT_PAGE_W 8
`endif

// file: src/pmt_core.sv
// Program store, fetch path and table read engine
`timescale 1ns/1ns
`include "pmt_consts.svh"
module pmt_core #(
    parameter int DEPTH = `PMT_DEPTH_WORDS,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic i_clk,                        // 50 MHz core clock
    input wire logic i_arst_n,                     // Async reset, low
    input wire logic i_cyc_en,                     // One pulse per instruction cycle
    input wire logic i_pc_load,                    // Branch: load new PC
    input wire logic [AW-1:0] i_pc_target,         // Branch target
    input wire logic i_tbl_rd,                     // Table read issued
    input wire pmt_pkg::pmt_tr_e i_tbl_form,       // Table read form
    input wire pmt_pkg::pmt_dst_s i_tbl_dst,       // Destination register
    input wire logic [7:0] i_tbl_lo_ptr,           // Low table pointer
    input wire logic [7:0] i_tbl_hi_ptr,           // High table pointer
    input wire logic i_hi_latch_wr,                // Software write to high latch
    input wire logic [7:0] i_hi_latch_wdata,       // Data for high latch
    input wire logic i_prog_we,                    // Programming word write
    input wire logic [AW-1:0] i_prog_addr,         // Programming address
    input wire logic [15:0] i_prog_wdata,          // Programming data
    input wire logic i_port_a_line0,               // Data pin level in
    input wire logic i_port_a_line2,               // Clock pin level in
    input wire logic i_prog_data_oe,               // Programmer wants to drive data
    input wire logic i_prog_data_out,              // Bit to drive out
    output logic [AW-1:0] o_pc,                    // Fetch address
    output logic [15:0] o_instr,                   // Fetched word
    output logic o_stall,                          // Core holds: dummy or 2nd cycle
    output pmt_pkg::pmt_dwr_s o_dwr,               // Low byte to data memory
    output logic o_dwr_ext,                        // Write came from extended form
    output logic [7:0] o_table_high_latch,         // High latch value
    output logic o_prog_serial_data_o,             // Data pin output
    output logic o_prog_serial_data_oe,            // Data pin enable
    output logic o_prog_serial_data,               // Synced data in
    output logic o_prog_serial_clock               // Synced clock in
);
    import pmt_pkg::*;

    logic [15:0] mem [DEPTH];
    pmt_state_e state;
    logic [AW-1:0] tbl_addr;
    logic [AW-1:0] next_tbl_addr;
    logic tbl_ext;
    pmt_dst_s tbl_dst;
    logic [2:0] sync_d;
    logic [2:0] sync_c;

    // Last page forms pin the page to the top of the store
    always_comb begin
        if (i_tbl_form[0]) begin
            next_tbl_addr = {{(AW-`PMT_PAGE_W){1'b1}}, i_tbl_lo_ptr};
        end else begin
            next_tbl_addr = AW'({i_tbl_hi_ptr, i_tbl_lo_ptr});
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_prog_we) begin
            mem[i_prog_addr] <= i_prog_wdata;
        end
    end

    // Sequencer: table read second cycle and branch dummy cycle
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= PMT_IDLE;
            o_stall <= 1'b0;
            tbl_addr <= '0;
            tbl_ext <= 1'b0;
            tbl_dst <= '0;
        end else if (i_cyc_en) begin
            case (state)
                PMT_IDLE: begin
                    if (i_tbl_rd) begin
                        state <= PMT_TBL1;
                        o_stall <= 1'b1;
                        tbl_addr <= next_tbl_addr;
                        tbl_ext <= i_tbl_form[1];
                        tbl_dst <= i_tbl_dst;
                    end else if (i_pc_load) begin
                        state <= PMT_DUMMY;
                        o_stall <= 1'b1;
                    end
                end
                PMT_TBL1, PMT_DUMMY: begin
                    state <= PMT_IDLE;
                    o_stall <= 1'b0;
                end
                default: begin
                    state <= PMT_IDLE;
                    o_stall <= 1'b0;
                end
            endcase
        end
    end

    // Fetch path; table read word is taken in its second cycle
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pc <= AW'(`PMT_RESET_VECTOR);
            o_instr <= '0;
        end else if (i_cyc_en) begin
            if (state == PMT_IDLE && i_pc_load && !i_tbl_rd) begin
                o_pc <= i_pc_target;
            end else if (state == PMT_IDLE && !i_tbl_rd) begin
                o_pc <= o_pc + AW'(1);
            end
            if (state != PMT_TBL1) begin
                o_instr <= mem[o_pc];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_dwr <= '0;
            o_dwr_ext <= 1'b0;
            o_table_high_latch <= `PMT_TBL_HI_RST;
        end else begin
            o_dwr.en <= 1'b0;
            if (i_cyc_en && state == PMT_TBL1) begin
                o_dwr.en <= 1'b1;
                o_dwr.dst <= tbl_dst;
                o_dwr.data <= mem[tbl_addr][7:0];
                o_dwr_ext <= tbl_ext;
                o_table_high_latch <= mem[tbl_addr][15:8];
            end else if (i_hi_latch_wr) begin
                o_table_high_latch <= i_hi_latch_wdata;
            end
        end
    end

    // Programming pins: three-stage sync, accept when stages 2 and 3 agree
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync_d <= '0;
            sync_c <= '0;
            o_prog_serial_data <= 1'b0;
            o_prog_serial_clock <= 1'b0;
            o_prog_serial_data_o <= 1'b0;
            o_prog_serial_data_oe <= 1'b0;
        end else begin
            sync_d <= {sync_d[1:0], i_port_a_line0};
            sync_c <= {sync_c[1:0], i_port_a_line2};
            if (sync_d[1] == sync_d[2]) begin
                o_prog_serial_data <= sync_d[2];
            end
            if (sync_c[1] == sync_c[2]) begin
                o_prog_serial_clock <= sync_c[2];
            end
            o_prog_serial_data_o <= i_prog_data_out;
            o_prog_serial_data_oe <= i_prog_data_oe;
        end
    end

    // Sequencer, table data, high latch and pin checks; everything here lives on the core clock
    tbl_two_cycle_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_IDLE && i_tbl_rd) |=> (state == PMT_TBL1 && o_stall))
        else $error("table read did not enter second cycle");
    tbl_done_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_TBL1) |=> (state == PMT_IDLE && !o_stall))
        else $error("table read took more than two cycles");
    tbl_pc_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_IDLE && i_tbl_rd) |=> $stable(o_pc))
        else $error("fetch address moved during table read");
    cyc_gate_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !i_cyc_en |=> ($stable(state) && $stable(o_pc)))
        else $error("sequencer advanced without cycle enable");
    tbl_addr_full_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_IDLE && i_tbl_rd && !i_tbl_form[0])
        |=> (tbl_addr == AW'({$past(i_tbl_hi_ptr), $past(i_tbl_lo_ptr)})))
        else $error("table address not built from both pointers");
    tbl_write_once_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_TBL1) |=> (o_dwr.en && o_dwr.dst == $past(tbl_dst)))
        else $error("table read low byte not written");
    store_bytes_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_TBL1)
        |=> (o_table_high_latch == $past(mem[tbl_addr][15:8])
            && o_dwr.data == $past(mem[tbl_addr][7:0])))
        else $error("table word bytes not delivered");
    dwr_cause_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        o_dwr.en |-> $past(state == PMT_TBL1 && i_cyc_en))
        else $error("stray data memory write");
    ext_flag_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_IDLE && i_tbl_rd) |=> (tbl_ext == $past(i_tbl_form[1])))
        else $error("extended form flag not captured");
    last_page_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_IDLE && i_tbl_rd && i_tbl_form[0])
        |=> (tbl_addr[AW-1:`PMT_PAGE_W] == '1))
        else $error("last page form missed last page");
    last_page_low_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_IDLE && i_tbl_rd && i_tbl_form[0])
        |=> (tbl_addr[`PMT_PAGE_W-1:0] == $past(i_tbl_lo_ptr)))
        else $error("last page word not from low pointer");
    pc_step_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_IDLE && !i_tbl_rd && !i_pc_load)
        |=> (o_pc == $past(o_pc) + AW'(1)))
        else $error("fetch address did not step");
    branch_dummy_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_IDLE && i_pc_load && !i_tbl_rd)
        |=> (state == PMT_DUMMY && o_pc == $past(i_pc_target)))
        else $error("branch without dummy cycle");
    dummy_end_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_cyc_en && state == PMT_DUMMY) |=> (state == PMT_IDLE && !o_stall && $stable(o_pc)))
        else $error("dummy cycle longer than one cycle");
    hi_latch_wr_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_hi_latch_wr && !(i_cyc_en && state == PMT_TBL1))
        |=> o_table_high_latch == $past(i_hi_latch_wdata))
        else $error("high latch write lost");
    latch_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!i_hi_latch_wr && !(i_cyc_en && state == PMT_TBL1))
        |=> $stable(o_table_high_latch))
        else $error("high latch changed without cause");
    pin_drive_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        1'b1 |=> (o_prog_serial_data_oe == $past(i_prog_data_oe)
            && o_prog_serial_data_o == $past(i_prog_data_out)))
        else $error("data pin drive not registered");
    pin_accept_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        $changed(o_prog_serial_data) |-> $past(sync_d[1] == sync_d[2]))
        else $error("data pin accepted before stages agreed");
endmodule : pmt_core

// file: src/pmt_pkg.sv
// Types shared by the program memory block
package pmt_pkg;
    typedef enum logic [1:0] {
        PMT_IDLE = 2'b00,
        PMT_TBL1 = 2'b01,
        PMT_DUMMY = 2'b10
    } pmt_state_e;
    typedef enum logic [1:0] {
        PMT_TR_SHORT = 2'b00,
        PMT_TR_LAST = 2'b01,
        PMT_TR_EXT = 2'b10,
        PMT_TR_EXT_LAST = 2'b11
    } pmt_tr_e;
    typedef struct packed {
        logic [1:0] sector;
        logic [7:0] addr;
    } pmt_dst_s;
    typedef struct packed {
        logic en;
        pmt_dst_s dst;
        logic [7:0] data;
    } pmt_dwr_s;
endpackage : pmt_pkg
